// file: hdl/stpg_map.svh
`ifndef STPG_MAP_SVH
`define STPG_MAP_SVH
`define STPG_CTRL_ADDR   8'h00
`define STPG_STATUS_ADDR 8'h04
`define STPG_DROP_ADDR   8'h08
`define STPG_CTRL_RESET  8'h44
`define STPG_TX          0
`define STPG_RX          1
`define STPG_LD          2
`define STPG_PORT_STRIDE 4
`define STPG_PROC_PORT   2'h3
`define STPG_PROC_MASK   3'h4
`define STPG_ALL_MASK    3'h7
`define STPG_RESP_OKAY   2'h0
`define STPG_RESP_SLVERR 2'h2
`define STPG_FIFO_DEPTH  8
`define STPG_DESC_W      8
`endif

// file: hdl/stpg_pkg.sv
`default_nettype none
package stpg_pkg;
  typedef enum logic [1:0] {
    STPG_DISCARDING,
    STPG_LEARNING,
    STPG_FORWARDING
  } stpg_state_type;
endpackage : stpg_pkg
`default_nettype wire

// file: hdl/stpg_gate.sv
// Notes on behaviour
// - Port 3 processor; ports 1,2 gated
// - Discarding port neither forwards nor accepts frames
// - Disabled, blocking, listening share discarding settings
// - Overriding static hits still reach processor
// - Learning disable stops source address learning
// - Learning state: learn, processor traffic only
// - Forwarding state: normal traffic and learning
// - Processor frames pass through port 3 MII
// - Tail tag: bits 1:0 port, 3:2 priority
`include "stpg_map.svh"
`default_nettype none

module stpg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0]      count, next_count;
  logic             push, pop;

  assign in_ready  = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Storage needs no reset; count guards it
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : stpg_fifo

module stpg_gate (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // AXI4-Lite slave
  input  wire logic [7:0] s_axi_awaddr,
  input  wire logic       s_axi_awvalid,
  output logic            s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  input  wire logic       s_axi_wvalid,
  output logic            s_axi_wready,
  output logic [1:0]      s_axi_bresp,
  output logic            s_axi_bvalid,
  input  wire logic       s_axi_bready,
  input  wire logic [7:0] s_axi_araddr,
  input  wire logic       s_axi_arvalid,
  output logic            s_axi_arready,
  output logic [31:0]     s_axi_rdata,
  output logic [1:0]      s_axi_rresp,
  output logic            s_axi_rvalid,
  input  wire logic       s_axi_rready,
  // Frame descriptors from lookup
  input  wire logic       in_valid,
  output logic            in_ready,
  input  wire logic [1:0] in_src,
  input  wire logic [2:0] in_dst,
  input  wire logic [1:0] in_prio,
  input  wire logic       in_override,
  // Gated decisions
  output logic            out_valid,
  input  wire logic       out_ready,
  output logic [2:0]      out_dst,
  output logic            out_learn,
  output logic [7:0]      out_tag
);
  logic [7:0]  ctrl, next_ctrl;
  logic [15:0] drops, next_drops;
  logic        bvalid_q, next_bvalid;
  logic [1:0]  bresp_q, next_bresp;
  logic        rvalid_q, next_rvalid;
  logic [1:0]  rresp_q, next_rresp;
  logic [31:0] rdata_q, next_rdata;
  logic        ov_q, next_ov;
  logic [2:0]  dst_q, next_dst;
  logic        learn_q, next_learn;
  logic [7:0]  tag_q, next_tag;
  logic        wr_go, rd_go, f_valid, f_ready, take;
  logic [7:0]  f_data;
  logic [1:0]  h_src, h_prio;
  logic [2:0]  h_dst, ing_mask;
  logic        h_ovr, from_port, sidx;
  logic [1:0]  p_tx, p_rx, p_ld, eg_ok;
  stpg_pkg::stpg_state_type p_st [2];

  stpg_fifo #(.WIDTH(`STPG_DESC_W), .DEPTH(`STPG_FIFO_DEPTH)) u_fifo (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   ({in_src, in_dst, in_prio, in_override}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  assign {h_src, h_dst, h_prio, h_ovr} = f_data;
  // Decision is made once, at the frame's head leaving the FIFO
  assign f_ready = !ov_q || out_ready;
  assign take    = f_valid && f_ready;

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      assign p_tx[p] = ctrl[`STPG_PORT_STRIDE*p+`STPG_TX];
      assign p_rx[p] = ctrl[`STPG_PORT_STRIDE*p+`STPG_RX];
      assign p_ld[p] = ctrl[`STPG_PORT_STRIDE*p+`STPG_LD];
      // All three classic blocked states land here alike
      assign p_st[p] = p_rx[p] ? stpg_pkg::STPG_FORWARDING :
                       p_ld[p] ? stpg_pkg::STPG_DISCARDING :
                                 stpg_pkg::STPG_LEARNING;
      // Egress: tx enable, or processor frames while learning
      assign eg_ok[p] = p_tx[p] ||
                        (h_src == `STPG_PROC_PORT && !p_ld[p]);
    end
  endgenerate

  assign from_port = h_src != `STPG_PROC_PORT && h_src != 2'h0;
  assign sidx      = h_src[1];

  always_comb begin
    ing_mask = `STPG_ALL_MASK;
    if (from_port && !p_rx[sidx]) begin
      // Only processor-bound traffic survives a closed ingress
      ing_mask = (h_ovr || !p_ld[sidx]) ? `STPG_PROC_MASK
                                        : 3'h0;
    end
  end

  always_comb begin
    next_ov    = ov_q && !out_ready;
    next_dst   = dst_q;
    next_learn = learn_q;
    next_tag   = tag_q;
    next_drops = drops;
    if (take) begin
      next_ov    = 1'b1;
      next_dst   = h_dst & ing_mask & {1'b1, eg_ok};
      next_learn = !from_port || !p_ld[sidx];
      next_tag   = {4'h0, h_prio, h_src};
      if ((h_dst & ing_mask & {1'b1, eg_ok}) == 3'h0) begin
        next_drops = drops + 16'h1;
      end
    end
  end

  // AXI4-Lite: address and data taken together, one at a time
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign rd_go = s_axi_arvalid && !rvalid_q;

  always_comb begin
    next_ctrl   = ctrl;
    next_bvalid = bvalid_q && !s_axi_bready;
    next_bresp  = bresp_q;
    next_rvalid = rvalid_q && !s_axi_rready;
    next_rresp  = rresp_q;
    next_rdata  = rdata_q;
    if (wr_go) begin
      next_bvalid = 1'b1;
      next_bresp  = `STPG_RESP_OKAY;
      if (s_axi_awaddr == `STPG_CTRL_ADDR) begin
        if (s_axi_wstrb[0]) begin
          next_ctrl = s_axi_wdata[7:0] & 8'h77;
        end
      end else if (s_axi_awaddr == `STPG_STATUS_ADDR ||
                   s_axi_awaddr == `STPG_DROP_ADDR) begin
        next_bresp = `STPG_RESP_OKAY;
      end else begin
        next_bresp = `STPG_RESP_SLVERR;
      end
    end
    if (rd_go) begin
      next_rvalid = 1'b1;
      next_rresp  = `STPG_RESP_OKAY;
      if (s_axi_araddr == `STPG_CTRL_ADDR) begin
        next_rdata = {24'h0, ctrl};
      end else if (s_axi_araddr == `STPG_STATUS_ADDR) begin
        next_rdata = {28'h0, p_st[1], p_st[0]};
      end else if (s_axi_araddr == `STPG_DROP_ADDR) begin
        next_rdata = {16'h0, drops};
      end else begin
        next_rdata = 32'h0;
        next_rresp = `STPG_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl     <= `STPG_CTRL_RESET;
      drops    <= 16'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= `STPG_RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q  <= `STPG_RESP_OKAY;
      rdata_q  <= 32'h0;
      ov_q     <= 1'b0;
      dst_q    <= 3'h0;
      learn_q  <= 1'b0;
      tag_q    <= 8'h0;
    end else begin
      ctrl     <= next_ctrl;
      drops    <= next_drops;
      bvalid_q <= next_bvalid;
      bresp_q  <= next_bresp;
      rvalid_q <= next_rvalid;
      rresp_q  <= next_rresp;
      rdata_q  <= next_rdata;
      ov_q     <= next_ov;
      dst_q    <= next_dst;
      learn_q  <= next_learn;
      tag_q    <= next_tag;
    end
  end

  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = rd_go;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign out_valid     = ov_q;
  assign out_dst       = dst_q;
  assign out_learn     = learn_q;
  assign out_tag       = tag_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_disc_closed: assert property (
    take && from_port && p_st[sidx] == stpg_pkg::STPG_DISCARDING && !h_ovr
    |=> out_valid && out_dst == 3'h0)
    else $error("discarding port passed a frame");
  a_override_proc: assert property (
    take && from_port && !p_rx[sidx] && h_ovr && h_dst[2]
    |=> out_dst == `STPG_PROC_MASK)
    else $error("override frame not sent to processor only");
  a_learn_off: assert property (
    take && from_port && p_ld[sidx] |=> !out_learn)
    else $error("learned with learning disabled");
  a_learning_state: assert property (
    take && from_port && p_st[sidx] == stpg_pkg::STPG_LEARNING
    |=> out_learn && (out_dst & 3'h3) == 3'h0)
    else $error("learning state misbehaved");
  a_forward_state: assert property (
    take && from_port && p_rx[sidx] && !p_ld[sidx] && &p_tx
    |=> out_dst == $past(h_dst) && out_learn)
    else $error("forwarding state altered frame");
  a_tail_tag: assert property (
    take |=> out_tag[1:0] == $past(h_src) && out_tag[3:2] == $past(h_prio)
    && out_tag[7:4] == 4'h0)
    else $error("tail tag fields wrong");
  a_egress_tx: assert property (
    take && h_src != `STPG_PROC_PORT && !p_tx[0] |=> !out_dst[0])
    else $error("egress to port without transmit enable");
  a_hold_decision: assert property (
    out_valid && !out_ready |=> $stable(out_dst) && $stable(out_learn)
    && $stable(out_tag))
    else $error("decision changed while held");
  a_disc_equal: assert property (
    rd_go && s_axi_araddr == `STPG_STATUS_ADDR && !p_tx[0] && !p_rx[0]
    && p_ld[0] |=> s_axi_rdata[1:0] == 2'(stpg_pkg::STPG_DISCARDING))
    else $error("discarding settings decoded wrongly");
  a_write_resp: assert property (
    wr_go |=> s_axi_bvalid)
    else $error("write response missing");

  c_discard_override: cover property (take && h_ovr && !p_rx[sidx]
                                      && from_port);
  c_learning_frame: cover property (take && from_port && p_st[sidx] ==
                                    stpg_pkg::STPG_LEARNING);
  c_fifo_full: cover property (!in_ready);
  c_ctrl_write: cover property (wr_go && s_axi_awaddr == `STPG_CTRL_ADDR);
endmodule : stpg_gate
`default_nettype wire

// file: bench/stpg_proc_model.sv
`default_nettype none
module stpg_proc_model (
  // Clock and pacing
  input  wire logic       ref_clk,
  input  wire logic       stall,
  // Ports the processor holds closed
  input  wire logic [1:0] shut,
  // Stream from the gate
  input  wire logic       out_valid,
  output logic            out_ready,
  input  wire logic [2:0] out_dst,
  input  wire logic       out_learn,
  input  wire logic [7:0] out_tag,
  // Last frame taken
  output logic            got,
  output logic            kept,
  output logic [2:0]      seen_dst,
  output logic            seen_learn,
  output logic [7:0]      seen_tag
);
  timeunit 1ns;
  timeprecision 100ps;
  // Slow answers come from the bench holding stall
  assign out_ready = !stall;
  always @(posedge ref_clk) begin
    got <= out_valid && out_ready;
    if (out_valid && out_ready) begin
      seen_dst   <= out_dst;
      seen_learn <= out_learn;
      seen_tag   <= out_tag;
      // Frames from a closed port are only looked at, never used
      kept <= !(out_tag[1:0] inside {2'h1, 2'h2} && shut[out_tag[1]]);
    end
  end
endmodule : stpg_proc_model
`default_nettype wire

// file: bench/stpg_gate_tb.sv
`default_nettype none
module stpg_gate_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, stall, got;
  logic        in_valid, in_ready, in_override, out_valid, out_ready;
  logic        out_learn, seen_learn, kept;
  logic [1:0]  s_axi_bresp, s_axi_rresp, in_src, in_prio, shut;
  logic [2:0]  in_dst, out_dst, seen_dst;
  logic [3:0]  s_axi_wstrb;
  logic [5:0]  hs;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, out_tag, seen_tag;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int          num_errors = 0;
  int          n_checks = 0;

  stpg_gate u_dut (
    .ref_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .in_valid, .in_ready, .in_src, .in_dst, .in_prio, .in_override,
    .out_valid, .out_ready, .out_dst, .out_learn, .out_tag
  );
  stpg_proc_model u_proc (
    .ref_clk, .stall, .out_valid, .out_ready, .out_dst, .out_learn,
    .out_tag, .got, .seen_dst, .seen_learn, .seen_tag, .shut, .kept
  );
  assign hs = {got, in_ready, s_axi_rvalid, s_axi_arready, s_axi_bvalid,
               s_axi_awready & s_axi_wready};

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  task automatic check(string what, logic [31:0] exp, logic [31:0] seen);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Handshakes are judged on values sampled at the edge
  task automatic wait_on(int w);
    for (int i = 0; i < 302; i++) begin
      @(posedge ref_clk);
      if (i > 300) begin
        num_errors++;
        test_done();
      end
      if (hs[w] === 1'b1) break;
    end
  endtask : wait_on

  task automatic axi_wr(logic [7:0] a, logic [31:0] d, logic [1:0] resp);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    wait_on(0);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    wait_on(1);
    s_axi_bready <= 1'b0;
    check("bresp", resp, s_axi_bresp);
    // Idle edge so a following call never reassigns bready at once
    @(posedge ref_clk);
  endtask : axi_wr

  task automatic axi_rd(logic [7:0] a, logic [31:0] d, logic [1:0] resp);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    wait_on(2);
    s_axi_arvalid <= 1'b0;
    wait_on(3);
    s_axi_rready <= 1'b0;
    check("rdata", d, s_axi_rdata);
    check("rresp", resp, s_axi_rresp);
    @(posedge ref_clk);
  endtask : axi_rd

  // Leaves in_valid high so frames can go back to back
  task automatic send(logic [1:0] s, logic [2:0] d, logic [1:0] p, logic o);
    in_src      <= s;
    in_dst      <= d;
    in_prio     <= p;
    in_override <= o;
    in_valid    <= 1'b1;
    wait_on(4);
  endtask : send

  task automatic expect_out(logic [2:0] d, logic l, logic [7:0] t);
    wait_on(5);
    check("out_dst", d, seen_dst);
    check("out_learn", l, seen_learn);
    check("out_tag", t, seen_tag);
  endtask : expect_out

  task automatic frame(logic [1:0] s, logic [2:0] d, logic [1:0] p, logic o,
                       logic [2:0] ed, logic el);
    send(s, d, p, o);
    in_valid <= 1'b0;
    expect_out(ed, el, {4'h0, p, s});
  endtask : frame

  task automatic t_regs;
    axi_rd(8'h00, 32'h44, 2'h0);
    axi_rd(8'h04, 32'h0, 2'h0);
    axi_wr(8'h04, 32'ha, 2'h0);
    axi_rd(8'h04, 32'h0, 2'h0);
    axi_wr(8'h10, 32'h1, 2'h2);
    axi_rd(8'h10, 32'h0, 2'h2);
    $display("test regs done");
  endtask : t_regs

  task automatic t_discard;
    frame(2'h1, 3'h6, 2'h1, 1'b0, 3'h0, 1'b0);
    frame(2'h2, 3'h5, 2'h2, 1'b1, 3'h4, 1'b0);
    check("kept", 1'b0, kept);
    frame(2'h2, 3'h5, 2'h0, 1'b0, 3'h0, 1'b0);
    frame(2'h3, 3'h4, 2'h3, 1'b0, 3'h4, 1'b1);
    axi_rd(8'h08, 32'h2, 2'h0);
    $display("test discard done");
  endtask : t_discard

  task automatic t_states;
    axi_wr(8'h00, 32'h0, 2'h0);
    shut <= 2'h0;
    axi_rd(8'h04, 32'h5, 2'h0);
    frame(2'h1, 3'h6, 2'h3, 1'b0, 3'h4, 1'b1);
    frame(2'h3, 3'h3, 2'h1, 1'b0, 3'h3, 1'b1);
    axi_wr(8'h00, 32'h33, 2'h0);
    axi_rd(8'h04, 32'ha, 2'h0);
    frame(2'h1, 3'h6, 2'h3, 1'b0, 3'h6, 1'b1);
    axi_wr(8'h00, 32'h32, 2'h0);
    frame(2'h2, 3'h1, 2'h0, 1'b0, 3'h0, 1'b1);
    $display("test states done");
  endtask : t_states

  task automatic t_change;
    stall <= 1'b1;
    send(2'h1, 3'h2, 2'h2, 1'b0);
    in_valid <= 1'b0;
    @(posedge ref_clk);
    axi_wr(8'h00, 32'h44, 2'h0);
    shut <= 2'h3;
    stall <= 1'b0;
    expect_out(3'h2, 1'b1, 8'h09);
    frame(2'h1, 3'h2, 2'h2, 1'b0, 3'h0, 1'b0);
    $display("test change done");
  endtask : t_change

  task automatic t_fifo;
    stall <= 1'b1;
    for (int k = 0; k < 9; k++) begin
      send(2'h3, 3'h4, k[1:0], 1'b0);
    end
    @(posedge ref_clk);
    check("in_ready", 1'b0, in_ready);
    in_valid <= 1'b0;
    stall    <= 1'b0;
    for (int k = 0; k < 9; k++) begin
      expect_out(3'h4, 1'b1, {4'h0, k[1:0], 2'h3});
    end
    $display("test fifo done");
  endtask : t_fifo

  initial begin
    sys_rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, in_valid, in_override, stall} = 4'h0;
    shut = 2'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {in_src, in_dst, in_prio} = 7'h0;
    s_axi_wstrb = 4'hf;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    t_regs();
    t_discard();
    t_states();
    t_change();
    t_fifo();
    test_done();
  end
endmodule : stpg_gate_tb
`default_nettype wire
